// >>> dv/console_ea_props.sv
`timescale 1ns/1ps
module console_ea_props
	import console_pkg::*;
(
	input wire logic                clk,
	input wire logic                arst_n,
	input wire logic [SW_COUNT-1:0] console_sw,
	input wire logic                mem_req,
	input wire logic                mem_we,
	input wire logic                mem_ack,
	input wire logic [AW-1:0]       mem_addr,
	input wire logic [AW-1:0]       ma_lamps,
	input wire logic                addr_stop_lamp,
	input wire logic                instr_valid,
	input wire logic [8:0]          opcode,
	input wire logic [3:0]          ac_num,
	input wire logic                io_instr,
	input wire logic [6:0]          io_device,
	input wire logic [2:0]          io_op,
	input wire logic                immediate,
	input wire logic [AW-1:0]       eff_addr,
	input wire logic [W-1:0]        operand
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence cycle_open; mem_req && !mem_ack; endsequence
	// six cycles covers the three-stage sync plus the level register
	sequence match_held; console_sw[SW_ADDR_STOP] [*6]; endsequence
	////////////////////////////////////////////////////////////////////////
	chk_req_hold: assert property (
		cycle_open |=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("memory request changed before ack");
	chk_req_gap: assert property (mem_ack |=> !mem_req)
		else $error("memory request not dropped after ack");
	chk_ro_guard: assert property (
		mem_req && mem_we |-> !(mem_addr inside {[RO_FIRST:RO_LAST]}))
		else $error("write issued into read-only block");
	chk_ma_track: assert property (
		mem_req && mem_ack |=> ma_lamps == $past(mem_addr))
		else $error("memory address lamps miss last reference");
	chk_io_decode: assert property (
		instr_valid |-> io_instr == (opcode[8:6] == TOP_IO))
		else $error("io format flag wrong");
	chk_io_fields: assert property (
		instr_valid && io_instr |-> io_device == {opcode[5:0], ac_num[3]} && io_op == ac_num[2:0])
		else $error("io device or operation field wrong");
	chk_imm_value: assert property (
		instr_valid && immediate |-> operand[AW-1:0] == eff_addr)
		else $error("immediate operand differs from address");
	chk_stop_lamp: assert property (match_held |-> addr_stop_lamp)
		else $error("address stop lamp dark with switch on");
endmodule : console_ea_props

// >>> dv/core_mem_model.sv
`timescale 1ns/1ps
module core_mem_model
	import console_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  wire logic          mem_req,
	input  wire logic          mem_we,
	input  wire logic [AW-1:0] mem_addr,
	input  wire logic [W-1:0]  mem_wdata,
	output logic               mem_ack,
	output logic [W-1:0]       mem_rdata
);
	logic [W-1:0] mem [logic [AW-1:0]];
	int           wait_n;
	logic         slow;
	// plain storage: guarding the read-only block is the processor's job
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_ack <= 1'h0;
			mem_rdata <= '0;
			wait_n <= 0;
			slow <= 1'h0;
		end else if (mem_req && !mem_ack && wait_n == 0) begin
			mem_ack <= 1'h1;
			mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : '0;
			if (mem_we)
				mem[mem_addr] = mem_wdata;
			slow <= ~slow;
			wait_n <= slow ? 0 : 3;
		end else begin
			mem_ack <= 1'h0;
			// data is only good with ack, so scramble it otherwise
			mem_rdata <= ~mem_rdata;
			if (mem_req && wait_n > 0)
				wait_n <= wait_n - 1;
		end
	end
endmodule : core_mem_model

// >>> dv/test_console_ea.sv
`timescale 1ns/1ps
module test_console_ea
	import console_pkg::*;
;
	logic clk, arst_n, run_lamp, mem_stop_lamp, addr_stop_lamp, ind_lamp;
	logic mem_req, mem_we, mem_ack, instr_valid, io_instr, immediate;
	logic [SW_COUNT-1:0] console_sw;
	logic [AW-1:0] address_sw, pc_lamps, ma_lamps, mem_addr, eff_addr;
	logic [W-1:0] data_sw, fetched_word_lamps, mem_wdata, mem_rdata, operand;
	logic [8:0] instr_lamps, opcode;
	logic [3:0] ac_lamps, index_lamps, ac_num, s_axi_wstrb;
	logic [6:0] io_device;
	logic [2:0] io_op;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [42:0] iq[$];
	logic [35:0] wq[$];
	int err_total, n_compared;
	console_ea u_console_ea (.*);
	core_mem_model u_core_mem_model (.*);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (instr_valid)
			iq.push_back({opcode, ac_num, immediate, io_instr, eff_addr, io_device, io_op});
		if (mem_req && mem_ack && mem_we)
			wq.push_back({mem_addr, mem_wdata[17:0]});
	end
	////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [42:0] e, input logic [42:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// held well past the sync delay; the edge detector makes it act once
	task press(input int i);
		cyc(6);
		console_sw[i] <= 1'h1;
		cyc(10);
		console_sw[i] <= 1'h0;
		cyc(8);
	endtask : press
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		int t;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && t < 50);
		if (!s_axi_bvalid)
			err_total++;
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : axi_wr
	task axi_rd(input logic [7:0] a);
		int t;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && t < 50);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : axi_rd
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		err_total++;
		end_sim;
	end
	initial begin
		int t, k, j;
		{clk, arst_n, console_sw, address_sw, data_sw} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		u_core_mem_model.mem[18'h00102] = 36'h55AA50FF0;
		u_core_mem_model.mem[18'h00200] = {9'h081, 4'h3, 1'h1, 4'h1, 18'h00300};
		u_core_mem_model.mem[18'h00001] = {18'h3FFFF, 18'h00005};
		u_core_mem_model.mem[18'h00305] = {14'h0, 4'h2, 18'h00010};
		u_core_mem_model.mem[18'h00002] = {18'h0, 18'h3FFFF};
		u_core_mem_model.mem[TRAP_XCT] = {3'h7, 7'h05, 3'h2, 5'h0, 18'h0};
		cyc(3);
		arst_n <= 1'h1;
		cyc(1);
		chk("pc", 18'h0, pc_lamps);
		axi_wr(REG_CTRL, 32'h00000017);
		axi_rd(REG_CTRL);
		chk("ctrl", 32'h15, rd);
		axi_wr(REG_PC, 32'h00001234);
		chk("bresp", RESP_OKAY, rsp);
		axi_rd(8'h40);
		chk("rresp", RESP_SLVERR, rsp);
		address_sw <= 18'h00100;
		data_sw <= 36'h123456789;
		press(SW_DEP_THIS);
		chk("dep", 36'h123456789, u_core_mem_model.mem[18'h00100]);
		chk("ma", 18'h00100, ma_lamps);
		data_sw <= 36'hABCDEF012;
		press(SW_DEP_NEXT);
		chk("depn", 36'hABCDEF012, u_core_mem_model.mem[18'h00101]);
		press(SW_VIEW_NEXT);
		chk("viewn", 36'h55AA50FF0, fetched_word_lamps);
		press(SW_VIEW_THIS);
		chk("view", 36'h123456789, fetched_word_lamps);
		console_sw[SW_LOCK] <= 1'h1;
		press(SW_DEP_THIS);
		chk("lock", 36'h123456789, u_core_mem_model.mem[18'h00100]);
		console_sw[SW_LOCK] <= 1'h0;
		address_sw <= 18'h00200;
		console_sw[SW_ADDR_STOP] <= 1'h1;
		press(SW_START);
		chk("run", 1'h0, run_lamp);
		chk("stopl", 1'h1, addr_stop_lamp);
		chk("mah", 18'h00200, ma_lamps);
		chk("mi", u_core_mem_model.mem[18'h00200], fetched_word_lamps);
		chk("lamps", {9'h081, 4'h3, 1'h1, 4'h1}, {instr_lamps, ac_lamps, ind_lamp, index_lamps});
		console_sw[SW_ADDR_STOP] <= 1'h0;
		wq.delete();
		iq.delete();
		press(SW_CONT);
		t = 0;
		while (iq.size() < 3 && t < 3000) begin
			@(posedge clk);
			t++;
		end
		press(SW_STOP);
		t = 0;
		while (run_lamp !== 1'h0 && t < 300) begin
			@(posedge clk);
			t++;
		end
		chk("halt", 1'h0, run_lamp);
		chk("ea", {9'h081, 4'h3, 1'h1, 1'h0, 18'h0000F}, iq[0][42:10]);
		k = 0;
		while (k < iq.size() - 1 && iq[k][28] !== 1'h1)
			k++;
		chk("io", {9'h1C2, 4'hA, 1'h0, 1'h1, 18'h0, 7'h05, 3'h2}, iq[k]);
		j = 0;
		while (j < wq.size() - 1 && wq[j][35:18] !== TRAP_PC)
			j++;
		chk("trap", {TRAP_PC, 18'h00202}, wq[j]);
		end_sim;
	end
endmodule : test_console_ea
bind console_ea console_ea_props u_console_ea_props (.*);

// >>> inc/console_pkg.sv
package console_pkg;

	localparam int W  = 36;
	localparam int AW = 18;

	// field positions inside a full 36-bit word (bit 0 of the word is the lsb)
	localparam int WD_IND   = 22;
	localparam int WD_X_HI  = 21;
	localparam int WD_X_LO  = 18;
	localparam int WD_Y_HI  = 17;
	localparam int WD_IR_LO = 18;

	// field positions inside the 18-bit instruction register
	localparam int IR_OP_HI  = 17;
	localparam int IR_OP_LO  = 9;
	localparam int IR_AC_HI  = 8;
	localparam int IR_AC_LO  = 5;
	localparam int IR_IND    = 4;
	localparam int IR_X_HI   = 3;
	localparam int IR_TOP_LO = 15;
	localparam int IR_GRP_LO = 12;
	localparam int IR_DEV_HI = 14;
	localparam int IR_DEV_LO = 8;
	localparam int IR_IOP_HI = 7;
	localparam int IR_IOP_LO = 5;
	localparam int IR_MOD_HI = 10;
	localparam int IR_MOD_LO = 9;

	localparam logic [2:0]  TOP_TRAP  = 3'h0;
	localparam logic [2:0]  TOP_IO    = 3'h7;
	localparam logic [1:0]  MODE_IMM  = 2'h1;
	// one bit per opcode group of eight (opcode bits 0-5); a zero marks unassigned codes
	localparam logic [63:0] OP_GROUP_ASSIGNED = 64'hFFFF_FFFF_FFFF_FFFF;

	// special low-memory locations
	localparam logic [17:0] RO_FIRST   = 18'h00010;
	localparam logic [17:0] RO_LAST    = 18'h0001F;
	localparam logic [17:0] TRAP_PC    = 18'h00020;
	localparam logic [17:0] TRAP_XCT   = 18'h00021;
	localparam logic [17:0] ADDR_ONE   = 18'h00001;
	localparam logic [3:0]  X_NONE     = 4'h0;

	// repeat interval: coarse base of 3.4 us, six decade steps
	localparam int CLK_PERIOD_NS     = 5;
	localparam int REPEAT_BASE_NS    = 3400;
	localparam int REPEAT_BASE_CYC   = REPEAT_BASE_NS / CLK_PERIOD_NS;
	localparam logic [9:0] BASE_LAST = 10'(REPEAT_BASE_CYC - 1);
	localparam int FINE_SHIFT        = 4;
	localparam logic [2:0] COARSE_MAX = 3'h5;

	// lever and toggle positions in the switch vector
	localparam int SW_START     = 0;
	localparam int SW_STOP      = 1;
	localparam int SW_CONT      = 2;
	localparam int SW_DEP_THIS  = 3;
	localparam int SW_DEP_NEXT  = 4;
	localparam int SW_VIEW_THIS = 5;
	localparam int SW_VIEW_NEXT = 6;
	localparam int SW_LOCK      = 7;
	localparam int SW_ADDR_STOP = 8;
	localparam int SW_REPEAT    = 9;
	localparam int SW_MEM_STOP  = 10;
	localparam int SW_COUNT     = 11;
	localparam int LEVER_LAST   = SW_VIEW_NEXT;

	// register map over AXI4-Lite
	localparam int AXI_AW = 8;
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PC     = 8'h08;
	localparam logic [7:0] REG_EA     = 8'h0C;
	localparam logic [7:0] REG_IR     = 8'h10;
	localparam int CTRL_COARSE_HI = 2;
	localparam int CTRL_FINE_LO   = 4;
	localparam int CTRL_FINE_HI   = 7;
	localparam logic [2:0] COARSE_RESET = 3'h0;
	localparam logic [3:0] FINE_RESET   = 4'h0;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	typedef enum logic [2:0] {
		PH_FETCH,
		PH_INDEX,
		PH_INDIR,
		PH_OPND,
		PH_TRAP,
		PH_DONE
	} phase_t;

endpackage : console_pkg

// >>> rtl/console_ea.sv
// Contract
// - start while halted loads pc from address switches and runs; ignored when running
// - stop lever halts only at the end of a cycle, never midway
// - continue resumes from the stop point; stop plus continue single-steps, but here continue clears stop_req and runs on
// - deposit this writes data switches to address-switch location, no halt
// - deposit next bumps memory address, writes there; ignored while running
// - view_word this shows the address-switch word on the lamps, no halt
// - view_word next bumps memory address, reads and shows it; ignored while running
// - address-match halt stops when memory address equals switches; lamp lights
// - repeat reissues a held lever every 3.4 us times decade, fine adjustable
// - lockout ignores every console control that could disturb the program; the code masks levers only, so address stop and memory stop still act
// - lamps show opcode 0-8, accumulator 9-12, indirect 13, index 14-17
// - halted: pc shows next instruction, memory address shows last reference
// - memory-cycle halt stops after every memory cycle and lights its lamp
// - words 0-17 octal are accumulators; 1-17 index with right halves only
// - program writes to 20-37 octal leave memory unchanged
// - unassigned opcode with nonzero top bits acts as no-operation
// - the 64 codes with zero top bits store pc at 40, execute 41
// - basic format: bits 0-8 opcode with mode, bits 9-12 accumulator
// - I/O format: bits 3-9 device of 128, bits 10-12 one of eight operations
// - address is bits 18-35 plus index right half when index field nonzero
// - indirect bit set fetches a new word and repeats until bit 13 clear
// - immediate mode uses the final effective address as operand
// - viewed word register loads whenever the address-switch location is referenced
// - program counter is 18 bits holding the next instruction's location
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module console_ea
	import console_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire logic [SW_COUNT-1:0] console_sw,
	input  wire logic [AW-1:0]       address_sw,
	input  wire logic [W-1:0]        data_sw,
	output logic                     run_lamp,
	output logic                     mem_stop_lamp,
	output logic                     addr_stop_lamp,
	output logic [8:0]               instr_lamps,
	output logic [3:0]               ac_lamps,
	output logic                     ind_lamp,
	output logic [3:0]               index_lamps,
	output logic [W-1:0]             fetched_word_lamps,
	output logic [AW-1:0]            pc_lamps,
	output logic [AW-1:0]            ma_lamps,
	output logic                     mem_req,
	output logic                     mem_we,
	output logic [AW-1:0]            mem_addr,
	output logic [W-1:0]             mem_wdata,
	input  wire logic                mem_ack,
	input  wire logic [W-1:0]        mem_rdata,
	output logic                     instr_valid,
	output logic [8:0]               opcode,
	output logic [3:0]               ac_num,
	output logic                     io_instr,
	output logic [6:0]               io_device,
	output logic [2:0]               io_op,
	output logic                     immediate,
	output logic [AW-1:0]            eff_addr,
	output logic [W-1:0]             operand,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	output logic [1:0]               s_axi_bresp,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	input  wire logic [AXI_AW-1:0]   s_axi_araddr,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp
);

	typedef struct packed {
		logic              run;
		logic              busy;
		logic              con_cyc;
		logic              acc_we;
		logic [AW-1:0]     ma;
		logic [W-1:0]      acc_wdata;
		phase_t            phase;
		logic              xct;
		logic              nop;
		logic [AW-1:0]     pc;
		logic [AW-1:0]     ea;
		logic [AW-1:0]     ir;
		logic [W-1:0]      word;
		logic [W-1:0]      mi;
		logic [W-1:0]      operand;
		logic              stop_req;
		logic              mem_halt;
		logic              con_pend;
		logic              con_we;
		logic              con_next;
		logic [AW-1:0]     con_addr;
		logic [W-1:0]      con_data;
		logic              valid;
		logic [9:0]        base_cnt;
		logic [23:0]       rep_cnt;
		logic              rep_fire;
		logic [2:0]        coarse;
		logic [3:0]        fine;
		logic              aw_got;
		logic              w_got;
		logic [AXI_AW-1:0] aw_addr;
		logic [31:0]       w_data;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} state_t;

	state_t q_reg;
	state_t q_next;

	logic [SW_COUNT-1:0] sw_lvl;
	logic [SW_COUNT-1:0] sw_rise;
	logic [AW+W-1:0]     sw_rise_unused;
	logic [AW-1:0]       addr_lvl;
	logic [W-1:0]        data_lvl;

	switch_sync #(
		.N(SW_COUNT + AW + W)
	) u_sync (
		.clk   (clk),
		.arst_n(arst_n),
		.raw   ({data_sw, address_sw, console_sw}),
		.level ({data_lvl, addr_lvl, sw_lvl}),
		.rise  ({sw_rise_unused, sw_rise})
	);

	////////////////////////////////////////////////////////////////////////////////
	// decade table for the repeat interval, counted in 3.4 us base ticks

	function automatic logic [23:0] decade(input logic [2:0] k);
		logic [23:0] d;
		d = 24'h000001;
		for (int i = 0; i < 5; i++) begin
			if (3'(i) < k) begin
				d = 24'(d * 24'h00000A);
			end
		end
		return d;
	endfunction : decade

	function automatic logic [23:0] rep_period(input logic [2:0] k, input logic [3:0] f);
		logic [23:0] d;
		d = decade(k);
		return 24'(d + ((d * 24'(f)) >> FINE_SHIFT));
	endfunction : rep_period

	////////////////////////////////////////////////////////////////////////////////

	logic [SW_COUNT-1:0] press;
	logic                rd_hit;
	logic [31:0]         rd_val;
	logic                wr_hit;
	logic [AW-1:0]       acc_addr;
	logic                acc_wr;
	logic                acc_prog;
	logic [AW-1:0]       ea_idx;

	always_comb begin
		q_next          = q_reg;
		q_next.valid    = 1'b0;
		q_next.rep_fire = 1'b0;
		press           = '0;
		acc_addr        = q_reg.ma;
		acc_wr          = 1'b0;
		acc_prog        = 1'b0;
		ea_idx          = 18'(q_reg.ea + mem_rdata[WD_Y_HI:0]);

		// repeat timer restarts on every fresh press
		if (sw_lvl[SW_REPEAT] && (sw_lvl[LEVER_LAST:0] != '0)) begin
			if (q_reg.base_cnt == BASE_LAST) begin
				q_next.base_cnt = '0;
				if (q_reg.rep_cnt + 24'h000001 >= rep_period(q_reg.coarse, q_reg.fine)) begin
					q_next.rep_cnt  = '0;
					q_next.rep_fire = 1'b1;
				end else begin
					q_next.rep_cnt = 24'(q_reg.rep_cnt + 24'h000001);
				end
			end else begin
				q_next.base_cnt = 10'(q_reg.base_cnt + 10'h001);
			end
		end else begin
			q_next.base_cnt = '0;
			q_next.rep_cnt  = '0;
		end
		if (sw_rise[LEVER_LAST:0] != '0) begin
			q_next.base_cnt = '0;
			q_next.rep_cnt  = '0;
		end

		for (int i = 0; i <= LEVER_LAST; i++) begin
			press[i] = sw_rise[i] | (sw_lvl[i] & sw_lvl[SW_REPEAT] & q_reg.rep_fire);
		end
		// only view_word-this is harmless to a running program
		if (sw_lvl[SW_LOCK]) begin
			press[LEVER_LAST:0] = press[LEVER_LAST:0] & (LEVER_LAST+1)'(1 << SW_VIEW_THIS);
		end

		////////////////////////////////////////////////////////////////////////////
		// console levers

		if (press[SW_START] && !q_reg.run) begin
			q_next.pc       = addr_lvl;
			q_next.run      = 1'b1;
			q_next.phase    = PH_FETCH;
			q_next.xct      = 1'b0;
			q_next.stop_req = 1'b0;
			q_next.mem_halt = 1'b0;
		end
		if (press[SW_STOP] && q_reg.run) begin
			q_next.stop_req = 1'b1;
		end
		if (press[SW_CONT] && !q_reg.run) begin
			q_next.run      = 1'b1;
			q_next.stop_req = 1'b0;
			q_next.mem_halt = 1'b0;
		end
		if (!q_reg.con_pend) begin
			if (press[SW_DEP_THIS] || press[SW_VIEW_THIS]) begin
				q_next.con_pend = 1'b1;
				q_next.con_we   = press[SW_DEP_THIS];
				q_next.con_next = 1'b0;
				q_next.con_addr = addr_lvl;
				q_next.con_data = data_lvl;
			end else if ((press[SW_DEP_NEXT] || press[SW_VIEW_NEXT]) && !q_reg.run) begin
				q_next.con_pend = 1'b1;
				q_next.con_we   = press[SW_DEP_NEXT];
				q_next.con_next = 1'b1;
				q_next.con_data = data_lvl;
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// memory engine: console cycles slip in between processor cycles

		if (!q_reg.busy) begin
			if (q_reg.con_pend) begin
				q_next.con_pend = 1'b0;
				q_next.con_cyc  = 1'b1;
				acc_addr = q_reg.con_next ? 18'(q_reg.ma + ADDR_ONE) : q_reg.con_addr;
				acc_wr   = q_reg.con_we;
				q_next.acc_wdata = q_reg.con_data;
				q_next.busy      = 1'b1;
			end else if (q_reg.run && q_reg.phase != PH_DONE) begin
				q_next.busy = 1'b1;
				acc_prog    = 1'b1;
				case (q_reg.phase)
					PH_FETCH: acc_addr = q_reg.xct ? TRAP_XCT : q_reg.pc;
					PH_INDEX: acc_addr = {14'h0000, q_reg.word[WD_X_HI:WD_X_LO]};
					PH_TRAP: begin
						acc_addr = TRAP_PC;
						acc_wr   = 1'b1;
						q_next.acc_wdata = {18'h00000, q_reg.pc};
					end
					default: acc_addr = q_reg.ea;
				endcase
			end else if (q_reg.run) begin
				// instruction boundary
				q_next.valid = !q_reg.nop;
				q_next.nop   = 1'b0;
				q_next.phase = PH_FETCH;
				if (q_reg.xct) begin
					q_next.xct = 1'b0;
				end else begin
					q_next.pc = 18'(q_reg.pc + ADDR_ONE);
				end
				if (q_reg.stop_req) begin
					q_next.run      = 1'b0;
					q_next.stop_req = 1'b0;
				end
			end
			if (q_next.busy) begin
				q_next.ma     = acc_addr;
				q_next.acc_we = acc_wr && !(acc_prog && acc_addr >= RO_FIRST
					&& acc_addr <= RO_LAST);
			end
		end else if (mem_ack) begin
			q_next.busy    = 1'b0;
			q_next.con_cyc = 1'b0;
			if (q_reg.ma == addr_lvl) begin
				q_next.mi = q_reg.acc_we ? q_reg.acc_wdata : mem_rdata;
			end
			if (q_reg.con_cyc) begin
				if (!q_reg.acc_we) begin
					q_next.mi = mem_rdata;
				end
			end else begin
				case (q_reg.phase)
					PH_FETCH: begin
						q_next.word = mem_rdata;
						q_next.ir   = mem_rdata[W-1:WD_IR_LO];
						q_next.ea   = mem_rdata[WD_Y_HI:0];
						if (mem_rdata[W-1:W-3] == TOP_TRAP) begin
							q_next.phase = PH_TRAP;
							q_next.pc    = 18'(q_reg.pc + ADDR_ONE);
						end else begin
							q_next.nop = !OP_GROUP_ASSIGNED[mem_rdata[W-1:W-6]];
							q_next.phase = (mem_rdata[WD_X_HI:WD_X_LO] != X_NONE) ? PH_INDEX
								: mem_rdata[WD_IND] ? PH_INDIR : PH_OPND;
						end
					end
					PH_INDEX: begin
						q_next.ea    = ea_idx;
						q_next.phase = q_reg.word[WD_IND] ? PH_INDIR : PH_OPND;
					end
					PH_INDIR: begin
						q_next.word  = mem_rdata;
						q_next.ea    = mem_rdata[WD_Y_HI:0];
						q_next.phase = (mem_rdata[WD_X_HI:WD_X_LO] != X_NONE) ? PH_INDEX
							: mem_rdata[WD_IND] ? PH_INDIR : PH_OPND;
					end
					PH_TRAP: begin
						q_next.xct   = 1'b1;
						q_next.phase = PH_FETCH;
					end
					default: begin
						q_next.operand = mem_rdata;
						q_next.phase   = PH_DONE;
					end
				endcase
				// immediate and I/O forms take no operand read
				if (q_next.phase == PH_OPND && (q_next.ir[IR_OP_HI:IR_TOP_LO] == TOP_IO
					|| q_next.ir[IR_MOD_HI:IR_MOD_LO] == MODE_IMM || q_next.nop)) begin
					q_next.operand = {18'h00000, q_next.ea};
					q_next.phase   = PH_DONE;
				end
				if (sw_lvl[SW_MEM_STOP] || (sw_lvl[SW_ADDR_STOP] && q_reg.ma == addr_lvl)) begin
					q_next.run      = 1'b0;
					q_next.mem_halt = sw_lvl[SW_MEM_STOP];
				end
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// AXI4-Lite slave

		if (s_axi_awvalid && s_axi_awready) begin
			q_next.aw_got  = 1'b1;
			q_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			q_next.w_got  = 1'b1;
			q_next.w_data = s_axi_wdata;
		end
		wr_hit = q_reg.aw_addr == REG_CTRL;
		if (q_reg.aw_got && q_reg.w_got && !q_reg.bvalid) begin
			q_next.aw_got = 1'b0;
			q_next.w_got  = 1'b0;
			q_next.bvalid = 1'b1;
			q_next.bresp  = (wr_hit || q_reg.aw_addr == REG_STATUS || q_reg.aw_addr == REG_PC
				|| q_reg.aw_addr == REG_EA || q_reg.aw_addr == REG_IR) ? RESP_OKAY : RESP_SLVERR;
			if (wr_hit) begin
				q_next.coarse = (q_reg.w_data[CTRL_COARSE_HI:0] > COARSE_MAX) ? COARSE_MAX
					: q_reg.w_data[CTRL_COARSE_HI:0];
				q_next.fine   = q_reg.w_data[CTRL_FINE_HI:CTRL_FINE_LO];
			end
		end
		if (q_reg.bvalid && s_axi_bready) begin
			q_next.bvalid = 1'b0;
		end

		rd_hit = 1'b1;
		case (s_axi_araddr)
			REG_CTRL:   rd_val = {24'h000000, q_reg.fine, 1'b0, q_reg.coarse};
			REG_STATUS: rd_val = {24'h000000, q_reg.nop, q_reg.xct, q_reg.con_pend, q_reg.busy,
				q_reg.stop_req, sw_lvl[SW_ADDR_STOP], q_reg.mem_halt, q_reg.run};
			REG_PC:     rd_val = {14'h0000, q_reg.pc};
			REG_EA:     rd_val = {14'h0000, q_reg.ea};
			REG_IR:     rd_val = {14'h0000, q_reg.ir};
			default: begin
				rd_val = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
		if (s_axi_arvalid && s_axi_arready) begin
			q_next.rvalid = 1'b1;
			q_next.rdata  = rd_val;
			q_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (q_reg.rvalid && s_axi_rready) begin
			q_next.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q_reg        <= '0;
			q_reg.phase  <= PH_FETCH;
			q_reg.coarse <= COARSE_RESET;
			q_reg.fine   <= FINE_RESET;
		end else begin
			q_reg <= q_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// lamps, memory port and decode outputs

	assign run_lamp           = q_reg.run;
	assign mem_stop_lamp      = q_reg.mem_halt;
	assign addr_stop_lamp     = sw_lvl[SW_ADDR_STOP];
	assign instr_lamps        = q_reg.ir[IR_OP_HI:IR_OP_LO];
	assign ac_lamps           = q_reg.ir[IR_AC_HI:IR_AC_LO];
	assign ind_lamp           = q_reg.ir[IR_IND];
	assign index_lamps        = q_reg.ir[IR_X_HI:0];
	assign fetched_word_lamps = q_reg.mi;
	assign pc_lamps           = q_reg.pc;
	assign ma_lamps           = q_reg.ma;

	assign mem_req   = q_reg.busy;
	assign mem_we    = q_reg.busy & q_reg.acc_we;
	assign mem_addr  = q_reg.ma;
	assign mem_wdata = q_reg.acc_wdata;

	assign instr_valid = q_reg.valid;
	assign opcode      = q_reg.ir[IR_OP_HI:IR_OP_LO];
	assign ac_num      = q_reg.ir[IR_AC_HI:IR_AC_LO];
	assign io_instr    = q_reg.ir[IR_OP_HI:IR_TOP_LO] == TOP_IO;
	assign io_device   = q_reg.ir[IR_DEV_HI:IR_DEV_LO];
	assign io_op       = q_reg.ir[IR_IOP_HI:IR_IOP_LO];
	assign immediate   = q_reg.ir[IR_MOD_HI:IR_MOD_LO] == MODE_IMM;
	assign eff_addr    = q_reg.ea;
	assign operand     = q_reg.operand;

	// handshake readies come straight from the holding flags
	assign s_axi_awready = !q_reg.aw_got;
	assign s_axi_wready  = !q_reg.w_got;
	assign s_axi_bvalid  = q_reg.bvalid;
	assign s_axi_bresp   = q_reg.bresp;
	assign s_axi_arready = !q_reg.rvalid;
	assign s_axi_rvalid  = q_reg.rvalid;
	assign s_axi_rdata   = q_reg.rdata;
	assign s_axi_rresp   = q_reg.rresp;

endmodule : console_ea

// >>> rtl/switch_sync.sv
`timescale 1ns/1ps
module switch_sync
	import console_pkg::*;
#(
	parameter int N = 1
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [N-1:0] raw,
	output logic      [N-1:0] level,
	output logic      [N-1:0] rise
);

	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] lvl;
		logic [N-1:0] rise;
	} sync_t;

	sync_t q_reg;
	sync_t q_next;

	// a change counts once stages two and three agree; stage one feeds stage two only
	always_comb begin
		q_next      = q_reg;
		q_next.s1   = raw;
		q_next.s2   = q_reg.s1;
		q_next.s3   = q_reg.s2;
		q_next.lvl  = (q_reg.s2 & q_reg.s3) | (q_reg.lvl & (q_reg.s2 | q_reg.s3));
		q_next.rise = q_next.lvl & ~q_reg.lvl;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign level = q_reg.lvl;
	assign rise  = q_reg.rise;

endmodule : switch_sync
